// >>> cbd_pkg.sv
// Shared types and constants for the branch, bit and ALU decode core
package cbd_pkg;

  // ----------------------------------------------------------------
  // Condition codes and bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cbd_ccr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
  } cbd_bus_t;

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    S_OPC  = 10'h001,
    S_OPA  = 10'h002,
    S_OPB  = 10'h004,
    S_MEM  = 10'h008,
    S_REL  = 10'h010,
    S_WR   = 10'h020,
    S_PSL  = 10'h040,
    S_PSH  = 10'h080,
    S_PAD  = 10'h100,
    S_HALT = 10'h200
  } cbd_state_t;

  typedef enum logic [2:0] {
    ALU_PASS = 3'h0,
    ALU_ADC  = 3'h1,
    ALU_ADD  = 3'h2,
    ALU_AND  = 3'h3,
    ALU_ASL  = 3'h4,
    ALU_ASR  = 3'h5,
    ALU_SET_MEMORY_BIT = 3'h6,
    ALU_CLEAR_MEMORY_BIT = 3'h7
  } cbd_alu_op_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_PC = 16'h0100;
  localparam logic [7:0]  RESET_SP = 8'hff;
  localparam logic [7:0]  RESET_AX = 8'h00;
  localparam cbd_ccr_t    RESET_CCR = '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};

  // ----------------------------------------------------------------
  // Opcodes and opcode fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_BHI  = 8'h22;
  localparam logic [7:0] OP_BCC  = 8'h24;
  localparam logic [7:0] OP_BCS  = 8'h25;
  localparam logic [7:0] OP_BEQ  = 8'h27;
  localparam logic [7:0] OP_BRANCH_HALFCARRY_ZERO = 8'h28;
  localparam logic [7:0] OP_BRANCH_HALFCARRY_ONE = 8'h29;
  localparam logic [7:0] OP_BIL  = 8'h2e;
  localparam logic [7:0] OP_BIH  = 8'h2f;
  localparam logic [7:0] OP_STOP = 8'h8e;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [3:0] LO_ADC  = 4'h9;
  localparam logic [3:0] LO_ADD  = 4'hb;
  localparam logic [3:0] LO_AND  = 4'h4;
  localparam logic [3:0] LO_ASL  = 4'h8;
  localparam logic [3:0] LO_ASR  = 4'h7;
  localparam logic [3:0] LO_JMP  = 4'hc;
  localparam logic [3:0] LO_JSR  = 4'hd;
  localparam logic [3:0] HI_BRB  = 4'h0;
  localparam logic [3:0] HI_BOP  = 4'h1;
  localparam logic [3:0] HI_IMM  = 4'ha;
  localparam logic [3:0] HI_DIR  = 4'hb;
  localparam logic [3:0] HI_EXT  = 4'hc;
  localparam logic [3:0] HI_IX2  = 4'hd;
  localparam logic [3:0] HI_IX1  = 4'he;
  localparam logic [3:0] HI_IX   = 4'hf;
  localparam logic [3:0] HI_RDIR = 4'h3;
  localparam logic [3:0] HI_RA   = 4'h4;
  localparam logic [3:0] HI_RX   = 4'h5;
  localparam logic [3:0] HI_RIX1 = 4'h6;
  localparam logic [3:0] HI_RIX  = 4'h7;
  localparam logic [7:0] PAGE0   = 8'h00;

  // ----------------------------------------------------------------
  // Cycle counts per instruction form
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_IMM     = 3'h2;
  localparam logic [2:0] CYC_DIR     = 3'h3;
  localparam logic [2:0] CYC_EXT     = 3'h4;
  localparam logic [2:0] CYC_IX2     = 3'h5;
  localparam logic [2:0] CYC_IX1     = 3'h4;
  localparam logic [2:0] CYC_IX      = 3'h3;
  localparam logic [2:0] CYC_RMW_DIR = 3'h5;
  localparam logic [2:0] CYC_RMW_INH = 3'h3;
  localparam logic [2:0] CYC_RMW_IX1 = 3'h6;
  localparam logic [2:0] CYC_RMW_IX  = 3'h5;
  localparam logic [2:0] CYC_BRANCH  = 3'h3;
  localparam logic [2:0] CYC_BIT     = 3'h5;
  localparam logic [2:0] CYC_MIN     = 3'h1;
  localparam logic [2:0] CYC_NOP     = 3'h2;

endpackage : cbd_pkg

// >>> cbd_alu.sv
// Arithmetic, logic, shift and bit-modify unit
`timescale 1ns/1ps
module cbd_alu (
  input  wire cbd_pkg::cbd_alu_op_t i_op,
  input  wire logic [7:0]           i_a,
  input  wire logic [7:0]           i_b,
  input  wire logic [2:0]           i_bit,
  input  wire cbd_pkg::cbd_ccr_t    i_ccr,
  output logic [7:0]                o_res,
  output cbd_pkg::cbd_ccr_t         o_ccr
);

  // ----------------------------------------------------------------
  // Operand paths
  // ----------------------------------------------------------------
  wire        cin  = (i_op == cbd_pkg::ALU_ADC) ? i_ccr.c : 1'b0;
  wire [8:0]  sum  = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
  wire [4:0]  nib  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
  wire [7:0]  mask = 8'h01 << i_bit;
  wire        arith = (i_op == cbd_pkg::ALU_ADC) || (i_op == cbd_pkg::ALU_ADD);
  wire        shl  = (i_op == cbd_pkg::ALU_ASL);
  wire        shr  = (i_op == cbd_pkg::ALU_ASR);
  wire        land = (i_op == cbd_pkg::ALU_AND);
  wire        nz   = arith || shl || shr || land;

  // Result select; bit ops touch memory only, never flags
  assign o_res = arith ? sum[7:0] :
                 land  ? (i_a & i_b) :
                 shl   ? {i_a[6:0], 1'b0} :
                 shr   ? {i_a[7], i_a[7:1]} :
                 (i_op == cbd_pkg::ALU_SET_MEMORY_BIT) ? (i_a | mask) :
                 (i_op == cbd_pkg::ALU_CLEAR_MEMORY_BIT) ? (i_a & ~mask) :
                 i_a;

  // Flag update; interrupt mask never moves here
  assign o_ccr.i = i_ccr.i;
  assign o_ccr.h = arith ? nib[4] : i_ccr.h;
  assign o_ccr.n = nz ? o_res[7] : i_ccr.n;
  assign o_ccr.z = nz ? (o_res == 8'h00) : i_ccr.z;
  assign o_ccr.c = arith ? sum[8] :
                   shl   ? i_a[7] :
                   shr   ? i_a[0] :
                   i_ccr.c;

endmodule : cbd_alu

// >>> cbd_core.sv
// Branch, bit-manipulation, control and ALU instruction sequencer
`timescale 1ns/1ps
module cbd_core (
  input  wire logic              i_core_clk,
  input  wire logic              i_arst_n,
  input  wire logic [7:0]        i_mem_rdata,
  input  wire logic              i_irq_pin,
  output cbd_pkg::cbd_bus_t      o_bus,
  output logic [15:0]            o_pc,
  output logic [7:0]             o_acc,
  output logic [7:0]             o_x,
  output cbd_pkg::cbd_ccr_t      o_ccr,
  output logic                   o_osc_stop,
  output logic                   o_cpu_clk_stop
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cbd_pkg::cbd_state_t state;
  cbd_pkg::cbd_state_t next_state;
  logic [2:0]          cyc;
  logic [2:0]          next_cyc;
  logic [15:0]         pc;
  logic [15:0]         next_pc;
  logic [7:0]          acc;
  logic [7:0]          next_acc;
  logic [7:0]          x;
  logic [7:0]          next_x;
  logic [7:0]          sp;
  logic [7:0]          next_sp;
  logic [7:0]          opc;
  logic [7:0]          next_opc;
  logic [7:0]          opa;
  logic [7:0]          next_opa;
  logic [15:0]         ea;
  logic [15:0]         next_ea;
  logic                take;
  logic                next_take;
  logic                osc_stop;
  logic                next_osc;
  logic                clk_stop;
  logic                next_clk;
  logic                fin;
  cbd_pkg::cbd_ccr_t   ccr;
  cbd_pkg::cbd_ccr_t   next_ccr;
  cbd_pkg::cbd_bus_t   bus;
  cbd_pkg::cbd_bus_t   next_bus;
  logic                irq_meta;
  logic                irq_sync;

  // ----------------------------------------------------------------
  // Interrupt pin synchroniser
  // ----------------------------------------------------------------
  // Pin is asynchronous to the core; only the second stage is used
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
    end else begin
      irq_meta <= i_irq_pin;
      irq_sync <= irq_meta;
    end
  end

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  // Opcode is live on the bus during its fetch cycle, held afterwards
  wire        in_opc = (state == cbd_pkg::S_OPC);
  wire [7:0]  op     = in_opc ? i_mem_rdata : opc;
  wire [3:0]  hi     = op[7:4];
  wire [3:0]  lo     = op[3:0];
  wire [2:0]  bitn   = op[3:1];
  wire        sense_low = op[0];
  wire        mem_hi = (hi >= cbd_pkg::HI_IMM);
  wire        is_alu = mem_hi && ((lo == cbd_pkg::LO_ADC) ||
                       (lo == cbd_pkg::LO_ADD) || (lo == cbd_pkg::LO_AND));
  wire        is_jmp = (hi >= cbd_pkg::HI_DIR) && (lo == cbd_pkg::LO_JMP);
  wire        is_jsr = (hi >= cbd_pkg::HI_DIR) && (lo == cbd_pkg::LO_JSR);
  wire        is_jump = is_jmp || is_jsr;
  wire        rmw_hi = (hi >= cbd_pkg::HI_RDIR) && (hi <= cbd_pkg::HI_RIX);
  wire        is_rmw = rmw_hi && ((lo == cbd_pkg::LO_ASL) || (lo == cbd_pkg::LO_ASR));
  wire        is_brb = (hi == cbd_pkg::HI_BRB);
  wire        is_bop = (hi == cbd_pkg::HI_BOP);
  wire        is_stop = (op == cbd_pkg::OP_STOP);
  wire        is_wait = (op == cbd_pkg::OP_WAIT);
  wire        is_rel = (op == cbd_pkg::OP_BHI) || (op == cbd_pkg::OP_BCC) ||
                       (op == cbd_pkg::OP_BCS) || (op == cbd_pkg::OP_BEQ) ||
                       (op == cbd_pkg::OP_BRANCH_HALFCARRY_ZERO) || (op == cbd_pkg::OP_BRANCH_HALFCARRY_ONE) ||
                       (op == cbd_pkg::OP_BIL) || (op == cbd_pkg::OP_BIH);
  wire        grp    = is_alu || is_jump;
  wire        known  = grp || is_rmw || is_brb || is_bop || is_rel;

  // Addressing mode per group
  wire m_imm = is_alu && (hi == cbd_pkg::HI_IMM);
  wire m_dir = (grp && (hi == cbd_pkg::HI_DIR)) || is_brb || is_bop ||
               (is_rmw && (hi == cbd_pkg::HI_RDIR));
  wire m_ext = grp && (hi == cbd_pkg::HI_EXT);
  wire m_ix2 = grp && (hi == cbd_pkg::HI_IX2);
  wire m_ix1 = (grp && (hi == cbd_pkg::HI_IX1)) || (is_rmw && (hi == cbd_pkg::HI_RIX1));
  wire m_ix  = (grp && (hi == cbd_pkg::HI_IX)) || (is_rmw && (hi == cbd_pkg::HI_RIX));
  wire m_inh = is_rmw && ((hi == cbd_pkg::HI_RA) || (hi == cbd_pkg::HI_RX));
  wire to_x  = is_rmw && (hi == cbd_pkg::HI_RX);

  // Cycles owed by this instruction; short sequences pad up to it
  wire [2:0] need_alu = m_imm ? cbd_pkg::CYC_IMM : m_dir ? cbd_pkg::CYC_DIR :
                        m_ext ? cbd_pkg::CYC_EXT : m_ix2 ? cbd_pkg::CYC_IX2 :
                        m_ix1 ? cbd_pkg::CYC_IX1 : cbd_pkg::CYC_IX;
  wire [2:0] need_rmw = m_dir ? cbd_pkg::CYC_RMW_DIR : m_ix1 ? cbd_pkg::CYC_RMW_IX1 :
                        m_ix ? cbd_pkg::CYC_RMW_IX : cbd_pkg::CYC_RMW_INH;
  wire [2:0] need = (is_brb || is_bop) ? cbd_pkg::CYC_BIT :
                    is_rel  ? cbd_pkg::CYC_BRANCH :
                    is_rmw  ? need_rmw :
                    is_alu  ? need_alu :
                    is_jump ? cbd_pkg::CYC_MIN : cbd_pkg::CYC_NOP;
  wire       done_go = ({1'b0, cyc} + 4'h1) >= {1'b0, need};

  // ----------------------------------------------------------------
  // Branch conditions
  // ----------------------------------------------------------------
  wire rel_cond =
    (op == cbd_pkg::OP_BHI)  ? !(ccr.c || ccr.z) :
    (op == cbd_pkg::OP_BCC)  ? !ccr.c :
    (op == cbd_pkg::OP_BCS)  ? ccr.c :
    (op == cbd_pkg::OP_BEQ)  ? ccr.z :
    (op == cbd_pkg::OP_BRANCH_HALFCARRY_ZERO) ? !ccr.h :
    (op == cbd_pkg::OP_BRANCH_HALFCARRY_ONE) ? ccr.h :
    (op == cbd_pkg::OP_BIH)  ? irq_sync :
    (op == cbd_pkg::OP_BIL)  ? !irq_sync : 1'b0;

  // Tested memory bit and whether its sense matches
  wire        mem_bit  = i_mem_rdata[bitn];
  wire        bit_take = mem_bit ^ sense_low;
  wire [15:0] rel_off  = {{8{i_mem_rdata[7]}}, i_mem_rdata};
  wire [15:0] pc_inc   = pc + 16'h0001;
  wire [15:0] rel_tgt  = pc_inc + rel_off;

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  // Direct and no-offset indexed forms land in page zero; one-byte offset indexed forms reach up to 0x01fe
  wire [15:0] x16    = {cbd_pkg::PAGE0, x};
  wire [15:0] rd16   = {cbd_pkg::PAGE0, i_mem_rdata};
  wire [15:0] ea_opa = m_ix1 ? (x16 + rd16) : rd16;
  wire [15:0] ea_opb = {opa, i_mem_rdata} + (m_ix2 ? x16 : 16'h0000);
  wire [15:0] ea_now = in_opc ? x16 : (state == cbd_pkg::S_OPA) ? ea_opa : ea_opb;
  wire        ea_ready = (in_opc && m_ix) ||
                         ((state == cbd_pkg::S_OPA) && (m_dir || m_ix1)) ||
                         ((state == cbd_pkg::S_OPB) && (m_ext || m_ix2));

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  wire cbd_pkg::cbd_alu_op_t alu_op =
    (is_alu && (lo == cbd_pkg::LO_ADC)) ? cbd_pkg::ALU_ADC :
    (is_alu && (lo == cbd_pkg::LO_ADD)) ? cbd_pkg::ALU_ADD :
    (is_alu && (lo == cbd_pkg::LO_AND)) ? cbd_pkg::ALU_AND :
    (is_rmw && (lo == cbd_pkg::LO_ASL)) ? cbd_pkg::ALU_ASL :
    (is_rmw && (lo == cbd_pkg::LO_ASR)) ? cbd_pkg::ALU_ASR :
    (is_bop && sense_low)               ? cbd_pkg::ALU_CLEAR_MEMORY_BIT :
    is_bop                              ? cbd_pkg::ALU_SET_MEMORY_BIT : cbd_pkg::ALU_PASS;
  wire [7:0] alu_a = is_alu ? acc : m_inh ? (to_x ? x : acc) : i_mem_rdata;
  logic [7:0]        alu_res;
  cbd_pkg::cbd_ccr_t alu_ccr;

  cbd_alu u_alu (
    .i_op  (alu_op),
    .i_a   (alu_a),
    .i_b   (i_mem_rdata),
    .i_bit (bitn),
    .i_ccr (ccr),
    .o_res (alu_res),
    .o_ccr (alu_ccr)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_pc    = pc;
    next_acc   = acc;
    next_x     = x;
    next_sp    = sp;
    next_ccr   = ccr;
    next_opc   = opc;
    next_opa   = opa;
    next_ea    = ea;
    next_take  = take;
    next_osc   = osc_stop;
    next_clk   = clk_stop;
    next_bus   = bus;
    next_bus.wr = 1'b0;
    fin        = 1'b0;
    case (state)
      cbd_pkg::S_OPC: begin
        next_opc = i_mem_rdata;
        next_pc  = pc_inc;
        next_bus.addr = pc_inc;
        if (is_stop) begin
          next_osc   = 1'b1;
          next_ccr.i = 1'b0;
          next_state = cbd_pkg::S_HALT;
        end else if (is_wait) begin
          next_clk   = 1'b1;
          next_ccr.i = 1'b0;
          next_state = cbd_pkg::S_HALT;
        end else if (m_inh) begin
          if (to_x) begin
            next_x = alu_res;
          end else begin
            next_acc = alu_res;
          end
          next_ccr = alu_ccr;
          fin = 1'b1;
        end else if (known && !m_ix) begin
          next_state = cbd_pkg::S_OPA;
        end else if (!known) begin
          fin = 1'b1;
        end
      end
      cbd_pkg::S_OPA: begin
        next_opa = i_mem_rdata;
        next_pc  = pc_inc;
        next_bus.addr = pc_inc;
        if (m_imm) begin
          next_acc = alu_res;
          next_ccr = alu_ccr;
          fin = 1'b1;
        end else if (is_rel) begin
          // Not taken: pc points at the offset byte, so pc_inc steps past it
          next_pc = rel_cond ? rel_tgt : pc_inc;
          fin = 1'b1;
        end else if (m_ext || m_ix2) begin
          next_state = cbd_pkg::S_OPB;
        end
      end
      cbd_pkg::S_OPB: begin
        next_pc = pc_inc;
      end
      cbd_pkg::S_MEM: begin
        if (is_alu) begin
          next_acc = alu_res;
          next_ccr = alu_ccr;
          fin = 1'b1;
        end else if (is_brb) begin
          next_ccr.c = mem_bit;
          next_take  = bit_take;
          next_bus.addr = pc;
          next_state = cbd_pkg::S_REL;
        end else begin
          // Read-modify-write: result goes back to the same address
          next_bus.wdata = alu_res;
          next_bus.wr    = 1'b1;
          next_ccr       = alu_ccr;
          next_state     = cbd_pkg::S_WR;
        end
      end
      cbd_pkg::S_REL: begin
        next_pc = take ? rel_tgt : pc_inc;
        fin = 1'b1;
      end
      cbd_pkg::S_WR: begin
        fin = 1'b1;
      end
      cbd_pkg::S_PSL: begin
        next_sp = sp - 8'h01;
        next_bus.addr  = {cbd_pkg::PAGE0, sp - 8'h01};
        next_bus.wdata = pc[15:8];
        next_bus.wr    = 1'b1;
        next_state = cbd_pkg::S_PSH;
      end
      cbd_pkg::S_PSH: begin
        next_sp = sp - 8'h01;
        next_pc = ea;
        fin = 1'b1;
      end
      cbd_pkg::S_PAD: begin
        fin = 1'b1;
      end
      cbd_pkg::S_HALT: begin
        // Wake while the synchronised interrupt pin is low; resume at next opcode
        if (!irq_sync) begin
          next_osc   = 1'b0;
          next_clk   = 1'b0;
          next_bus.addr = pc;
          next_state = cbd_pkg::S_OPC;
        end
      end
      default: begin
        next_bus.addr = pc;
        next_state = cbd_pkg::S_OPC;
      end
    endcase

    // Address resolved: jump, push return address, or fetch operand
    if (ea_ready) begin
      next_ea = ea_now;
      if (is_jmp) begin
        next_pc = ea_now;
        fin = 1'b1;
      end else if (is_jsr) begin
        next_bus.addr  = {cbd_pkg::PAGE0, sp};
        next_bus.wdata = next_pc[7:0];
        next_bus.wr    = 1'b1;
        next_state = cbd_pkg::S_PSL;
      end else begin
        next_bus.addr = ea_now;
        next_state = cbd_pkg::S_MEM;
      end
    end

    // End of instruction: pad to the owed cycle count, then fetch
    if (fin) begin
      next_state = done_go ? cbd_pkg::S_OPC : cbd_pkg::S_PAD;
      next_bus.addr = next_pc;
    end
    next_cyc = (next_state == cbd_pkg::S_OPC) ? 3'h0 : (cyc + 3'h1);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state    <= cbd_pkg::S_OPC;
      cyc      <= 3'h0;
      pc       <= cbd_pkg::RESET_PC;
      acc      <= cbd_pkg::RESET_AX;
      x        <= cbd_pkg::RESET_AX;
      sp       <= cbd_pkg::RESET_SP;
      ccr      <= cbd_pkg::RESET_CCR;
      opc      <= 8'h00;
      opa      <= 8'h00;
      ea       <= 16'h0000;
      take     <= 1'b0;
      osc_stop <= 1'b0;
      clk_stop <= 1'b0;
      bus      <= '{addr: cbd_pkg::RESET_PC, wdata: 8'h00, wr: 1'b0};
    end else begin
      state    <= next_state;
      cyc      <= next_cyc;
      pc       <= next_pc;
      acc      <= next_acc;
      x        <= next_x;
      sp       <= next_sp;
      ccr      <= next_ccr;
      opc      <= next_opc;
      opa      <= next_opa;
      ea       <= next_ea;
      take     <= next_take;
      osc_stop <= next_osc;
      clk_stop <= next_clk;
      bus      <= next_bus;
    end
  end

  // Outputs are the registers themselves
  assign o_bus          = bus;
  assign o_pc           = pc;
  assign o_acc          = acc;
  assign o_x            = x;
  assign o_ccr          = ccr;
  assign o_osc_stop     = osc_stop;
  assign o_cpu_clk_stop = clk_stop;

endmodule : cbd_core

// >>> cbd_mem_model.sv
// Asynchronous-read program and data memory facing the core bus
`timescale 1ns/1ps
module cbd_mem_model (
  input  wire logic              i_clk,
  input  wire cbd_pkg::cbd_bus_t i_bus,
  output logic [7:0]             o_rdata
);
  logic [7:0] mem [65536];
  // Unwritten bytes decode as no-ops, so stray fetches stay harmless
  initial foreach (mem[a]) mem[a] = 8'h9d;
  assign o_rdata = mem[i_bus.addr];
  // Write lands at the edge that ends the strobe cycle
  always @(posedge i_clk) if (i_bus.wr) mem[i_bus.addr] <= i_bus.wdata;
endmodule : cbd_mem_model

// >>> cbd_core_chk.sv
// Port-level checker for the branch, bit and ALU core
`timescale 1ns/1ps
module cbd_core_chk (
  input wire logic              i_core_clk,
  input wire logic              i_arst_n,
  input wire logic              i_irq_pin,
  input wire cbd_pkg::cbd_bus_t o_bus,
  input wire cbd_pkg::cbd_ccr_t o_ccr,
  input wire logic              o_osc_stop,
  input wire logic              o_cpu_clk_stop
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  // ----------------
  // Halt and wake
  // ----------------
  // Pin held long enough to pass the two-flop synchroniser
  sequence pin_high4; (o_osc_stop && i_irq_pin)[*4]; endsequence
  sequence pin_low3; (o_osc_stop && !i_irq_pin)[*3]; endsequence
  stop_unmask_a: assert property ($rose(o_osc_stop) |-> !o_ccr.i)
    else $error("stop entered with mask set");
  wait_unmask_a: assert property ($rose(o_cpu_clk_stop) |-> !o_ccr.i)
    else $error("wait entered with mask set");
  halt_excl_a: assert property (!(o_osc_stop && o_cpu_clk_stop))
    else $error("both halt flags high");
  halt_keep_a: assert property (pin_high4 |=> o_osc_stop)
    else $error("stop left with pin high");
  halt_wake_a: assert property (pin_low3 |-> ##[1:4] !o_osc_stop)
    else $error("stop not left with pin low");
  halt_quiet_a: assert property (o_osc_stop |-> !o_bus.wr)
    else $error("write while stopped");
  // ----------------
  // Memory writes
  // ----------------
  // Short-offset indexed shifts may write up to 0x01fe, so two pages are legal
  write_page_a: assert property (o_bus.wr |-> o_bus.addr[15:9] == 7'h00)
    else $error("write beyond the low two pages");
  // Shifts move N, Z and C with their write; H and I never move there
  write_flags_a: assert property (o_bus.wr |-> $stable(o_ccr.h) && $stable(o_ccr.i))
    else $error("flags moved on write");
endmodule : cbd_core_chk

// >>> cbd_core_bench.sv
// Self-checking bench for the branch, bit and ALU core
`timescale 1ns/1ps
module cbd_core_bench;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              irq = 1'b1;
  logic [7:0]        rdata;
  cbd_pkg::cbd_bus_t bus;
  logic [15:0]       pc;
  logic [7:0]        acc;
  logic [7:0]        x;
  cbd_pkg::cbd_ccr_t ccr;
  logic              osc_stop;
  logic              clk_stop;
  int                fail_count = 0;
  int                checks = 0;
  int                n;
  // Rows: branch opcode, pin level, taken with reset flags
  logic [9:0] rows [8] = '{{8'h22, 2'b11}, {8'h24, 2'b11}, {8'h25, 2'b10}, {8'h27, 2'b10},
    {8'h28, 2'b11}, {8'h29, 2'b10}, {8'h2f, 2'b11}, {8'h2e, 2'b01}};
  logic [7:0] prog [9] = '{8'h1f, 8'h40, 8'hab, 8'h85, 8'h57, 8'h48, 8'h8e, 8'h9d, 8'h8f};
  initial forever #12.5 clk = ~clk;
  cbd_core cbd_core_i (.i_core_clk(clk), .i_arst_n(arst_n), .i_mem_rdata(rdata),
    .i_irq_pin(irq), .o_bus(bus), .o_pc(pc), .o_acc(acc), .o_x(x), .o_ccr(ccr),
    .o_osc_stop(osc_stop), .o_cpu_clk_stop(clk_stop));
  cbd_mem_model cbd_mem_model_i (.i_clk(clk), .i_bus(bus), .o_rdata(rdata));
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Reset held four cycles; caller loads memory, then releases
  task restart(input logic pin);
    @(negedge clk);
    arst_n = 1'b0;
    irq = pin;
    repeat (4) @(negedge clk);
    chk("ccr", ccr, cbd_pkg::RESET_CCR);
  endtask : restart
  task close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // ----------------
  // Main sequence
  // ----------------
  // A no-op leads each branch so the synchronised pin has settled
  initial begin
    foreach (rows[r]) begin
      restart(rows[r][1]);
      cbd_mem_model_i.mem[16'h0101] = rows[r][9:2];
      cbd_mem_model_i.mem[16'h0102] = 8'h80;
      arst_n = 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("target", bus.addr, rows[r][0] ? 16'h0083 : 16'h0103);
      chk("pc", pc, rows[r][0] ? 16'h0083 : 16'h0103);
      $display("row %0d done", r);
    end
    // Bit test at +127, clear, add, shifts, stop and wake, then wait and wake
    restart(1'b1);
    cbd_mem_model_i.mem[16'h0040] = 8'h80;
    cbd_mem_model_i.mem[16'h0101] = 8'h0e;
    cbd_mem_model_i.mem[16'h0102] = 8'h40;
    cbd_mem_model_i.mem[16'h0103] = 8'h7f;
    foreach (prog[k]) cbd_mem_model_i.mem[16'h0183 + k] = prog[k];
    arst_n = 1'b1;
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk("bit_target", bus.addr, 16'h0183);
    chk("bit_carry", ccr.c, 1'b1);
    for (n = 0; n < 40 && osc_stop !== 1'b1; n++) @(negedge clk);
    chk("stopped", osc_stop, 1'b1);
    chk("cleared", cbd_mem_model_i.mem[16'h0040], 8'h00);
    chk("acc", acc, 8'h0a);
    chk("flags", ccr, 16'h0001);
    // Pin kept high long enough that the halt must hold
    repeat (5) @(negedge clk);
    chk("held", osc_stop, 1'b1);
    irq = 1'b0;
    for (n = 0; n < 40 && osc_stop !== 1'b0; n++) @(negedge clk);
    chk("woken", osc_stop, 1'b0);
    // Pin back high before the no-op ends, so the wait really halts
    irq = 1'b1;
    for (n = 0; n < 40 && clk_stop !== 1'b1; n++) @(negedge clk);
    repeat (5) @(negedge clk);
    chk("waiting", clk_stop, 1'b1);
    chk("wait_flags", ccr, 16'h0001);
    chk("index", x, 8'h00);
    irq = 1'b0;
    for (n = 0; n < 40 && clk_stop !== 1'b0; n++) @(negedge clk);
    chk("wait_woken", clk_stop, 1'b0);
    $display("program test done");
    close_out();
  end
endmodule : cbd_core_bench
bind cbd_core cbd_core_chk cbd_core_chk_i (.i_core_clk, .i_arst_n, .i_irq_pin, .o_bus,
  .o_ccr, .o_osc_stop, .o_cpu_clk_stop);
